// File: rtl/hprac_host.sv
`timescale 1ns/1ps
module hprac_host
  import hprac_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // host bus
  hprac_if.host           bus,
  // user command port
  input  wire logic       req_valid,
  input  wire hprac_op_t  req_op,
  input  wire logic [3:0] req_addr,
  input  wire logic [7:0] req_wdata,
  input  wire logic       chain_in,
  output logic            req_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata
);
  // ****************************************************************
  // sequencer
  // ****************************************************************
  hprac_state_t state;
  hprac_state_t next_state;
  hprac_op_t    op;
  logic [7:0]   count;
  logic [3:0]   addr;
  logic [7:0]   wdata;
  wire          count_done = (count == 8'h00);
  wire          accept     = req_valid & req_ready;
  // address and data settle on the pins one cycle before the strobes fall, except on an acknowledge, where they settle with irq_acknowledge_n
  wire [3:0]    next_addr  = accept ? req_addr : addr;
  wire [7:0]    next_wdata = accept ? req_wdata : wdata;
  assign req_ready = (state == HPRAC_IDLE);
  always_comb begin
    next_state = state;
    case (state)
      HPRAC_IDLE:    next_state = req_valid ? ((req_op == HPRAC_OP_ACK) ? HPRAC_CHAIN : HPRAC_SETUP) : HPRAC_IDLE;
      HPRAC_CHAIN:   next_state = count_done ? HPRAC_STROBE : HPRAC_CHAIN;
      HPRAC_SETUP:   next_state = (op == HPRAC_OP_RESET) ? HPRAC_HWRESET : HPRAC_STROBE;
      HPRAC_STROBE:  next_state = count_done ? HPRAC_RECOVER : HPRAC_STROBE;
      HPRAC_HWRESET: next_state = count_done ? HPRAC_RECOVER : HPRAC_HWRESET;
      HPRAC_RECOVER: next_state = count_done ? HPRAC_IDLE : HPRAC_RECOVER;
      default:       next_state = HPRAC_IDLE;
    endcase
  end
  wire          load_count = (next_state != state);
  wire [7:0]    next_count = (next_state == HPRAC_CHAIN)   ? 8'(CHAIN_WAIT_CYCLES - 1) :
                             (next_state == HPRAC_RECOVER) ? 8'(RECOVERY_CYCLES - 1) :
                             8'(STROBE_CYCLES - 1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= HPRAC_IDLE;
      count <= 8'h00;
    end else begin
      state <= next_state;
      count <= load_count ? next_count : (count_done ? 8'h00 : count - 8'h01);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op    <= HPRAC_OP_READ;
      addr  <= 4'h0;
      wdata <= 8'h00;
    end else if (req_valid & req_ready) begin
      op    <= req_op;
      addr  <= req_addr;
      wdata <= req_wdata;
    end
  end
  // ****************************************************************
  // pins
  // ****************************************************************
  wire strobing = (state == HPRAC_STROBE);
  wire acking   = (state == HPRAC_CHAIN) | (strobing & (op == HPRAC_OP_ACK));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.rd_n              <= 1'b1;
      bus.wr_n              <= 1'b1;
      bus.ce_n              <= 1'b1;
      bus.addr              <= 4'h0;
      bus.wdata             <= 8'h00;
      bus.irq_acknowledge_n <= 1'b1;
      bus.priority_chain_in <= 1'b0;
      rsp_valid             <= 1'b0;
      rsp_rdata             <= 8'h00;
    end else begin
      bus.priority_chain_in <= chain_in;
      bus.ce_n  <= ~((next_state == HPRAC_SETUP) | (next_state == HPRAC_STROBE) | (next_state == HPRAC_HWRESET))
                   | (op == HPRAC_OP_ACK & next_state == HPRAC_STROBE);
      bus.addr  <= next_addr;
      bus.wdata <= next_wdata;
      bus.irq_acknowledge_n <= ~((next_state == HPRAC_CHAIN) | (next_state == HPRAC_STROBE & op == HPRAC_OP_ACK));
      bus.rd_n <= ~((next_state == HPRAC_HWRESET) |
                    (next_state == HPRAC_STROBE & (op == HPRAC_OP_READ | op == HPRAC_OP_ACK)));
      bus.wr_n <= ~((next_state == HPRAC_HWRESET) | (next_state == HPRAC_STROBE & op == HPRAC_OP_WRITE));
      rsp_valid <= (state == HPRAC_RECOVER) & count_done & ~acking;
      if (strobing & count_done & (op == HPRAC_OP_READ | op == HPRAC_OP_ACK))
        rsp_rdata <= bus.rdata;
    end
  end
  // dummy reads are issued by the user as plain reads before the reset command
endmodule // hprac_host

// File: rtl/hprac_pkg.sv
package hprac_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 10;
  localparam int RESET_WIDTH_NS   = 150;
  localparam int RESET_CYCLES     = (RESET_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // recovery of 3.5 device clock periods, device clock one system clock here, rounded up
  localparam int RECOVERY_HALVES  = 7;
  localparam int RECOVERY_CYCLES  = (RECOVERY_HALVES + 1) / 2;
  localparam int STROBE_CYCLES    = RESET_CYCLES;
  localparam int CHAIN_WAIT_CYCLES = 4;
  // ****************************************************************
  // register selection and values
  // ****************************************************************
  localparam logic [3:0] REG_STATUS0   = 4'h0;
  localparam logic [3:0] REG_STATUS1   = 4'h1;
  localparam logic [3:0] REG_VECTOR    = 4'h2;
  localparam logic [3:0] REG_MASTER    = 4'h9;
  localparam logic [7:0] RESET_COMMAND = 8'hC0;
  localparam logic [1:0] STATUS0_HIGH  = 2'h1;
  localparam logic [2:0] STATUS0_LOW   = 3'h4;
  localparam logic [5:0] STATUS1_LOW   = 6'h06;
  localparam logic [7:0] VECTOR_RESET  = 8'h00;
  typedef enum logic [3:0] {
    HPRAC_IDLE     = 4'b0000,
    HPRAC_SETUP    = 4'b0001,
    HPRAC_STROBE   = 4'b0010,
    HPRAC_RECOVER  = 4'b0011,
    HPRAC_HWRESET  = 4'b0100,
    HPRAC_CHAIN    = 4'b0101
  } hprac_state_t;
  typedef enum logic [1:0] {
    HPRAC_OP_READ  = 2'b00,
    HPRAC_OP_WRITE = 2'b01,
    HPRAC_OP_RESET = 2'b10,
    HPRAC_OP_ACK   = 2'b11
  } hprac_op_t;
endpackage

// File: rtl/hprac_if.sv
`timescale 1ns/1ps
interface hprac_if;
  logic       rd_n;
  logic       wr_n;
  logic       ce_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rdata_oe;
  logic       irq_acknowledge_n;
  logic       priority_chain_in;
  logic       priority_chain_out;
  modport device (
    input  rd_n, wr_n, ce_n, addr, wdata, irq_acknowledge_n, priority_chain_in,
    output rdata, rdata_oe, priority_chain_out
  );
  modport host (
    output rd_n, wr_n, ce_n, addr, wdata, irq_acknowledge_n, priority_chain_in,
    input  rdata, rdata_oe, priority_chain_out
  );
endinterface

// File: rtl/hprac_device.sv
`timescale 1ns/1ps
// What this block does
// - writing C0h to master control resets all
// - host dummy-reads status 0, 1 first
// - status 0 reads 01XXX100 after reset
// - status 1 reads 0X000110 after reset
// - vector register read returns written value
// - later resets by command write or by both strobes low
// - both strobes low long enough resets
// - host leaves 3.5 clocks between accesses
// - host waits out chain delay before ack read
module hprac_device
  import hprac_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // host bus
  hprac_if.device         bus,
  // user side
  input  wire logic [2:0] ext_inputs,
  input  wire logic       ext_status1,
  input  wire logic       irq_pending,
  output logic            hw_reset_pulse,
  output logic [7:0]      vector
);
  // ****************************************************************
  // strobe decode
  // ****************************************************************
  logic [7:0] both_low_count;
  logic       rd_d;
  logic       wr_d;
  logic       reset_pending;
  logic       sel_d;
  wire        sel        = ~bus.ce_n;
  wire        both_low   = ~bus.rd_n & ~bus.wr_n;
  // select may lift on the same edge as the write strobe, so the stored select qualifies the rise
  wire        wr_rise    = ~wr_d & rd_d & bus.wr_n & bus.rd_n & sel_d;
  wire        rd_fall    = rd_d & ~bus.rd_n & bus.wr_n;
  wire        ack_read   = rd_fall & ~bus.irq_acknowledge_n;
  wire        reg_read   = rd_fall & sel & bus.irq_acknowledge_n;
  wire        cmd_reset  = wr_rise & (bus.addr == REG_MASTER) & (bus.wdata == RESET_COMMAND);
  wire        strobe_reset = both_low & (both_low_count == 8'(RESET_CYCLES - 1));
  wire        do_reset   = cmd_reset | strobe_reset;
  wire        vec_write  = wr_rise & (bus.addr == REG_VECTOR);
  // ****************************************************************
  // read data mux
  // ****************************************************************
  // status 0 pattern
  wire [7:0]  status0 = {STATUS0_HIGH, ext_inputs, STATUS0_LOW};
  wire [7:0]  status1 = {1'b0, ext_status1, STATUS1_LOW};
  logic [7:0] next_rdata;
  always_comb begin
    case (bus.addr)
      REG_STATUS0: next_rdata = status0;
      REG_STATUS1: next_rdata = status1;
      REG_VECTOR:  next_rdata = vector;
      default:     next_rdata = 8'h00;
    endcase
  end
  wire        chain_claim = bus.priority_chain_in & irq_pending;
  assign bus.priority_chain_out = bus.priority_chain_in & ~irq_pending;
  assign bus.rdata_oe = ~bus.rd_n & ((sel & bus.irq_acknowledge_n) | (~bus.irq_acknowledge_n & chain_claim));
  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_d           <= 1'b1;
      wr_d           <= 1'b1;
      sel_d          <= 1'b0;
      both_low_count <= 8'h00;
    end else begin
      rd_d           <= bus.rd_n;
      wr_d           <= bus.wr_n;
      sel_d          <= sel;
      both_low_count <= both_low ? ((both_low_count == 8'hFF) ? 8'hFF : both_low_count + 8'h01) : 8'h00;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector         <= VECTOR_RESET;
      bus.rdata      <= 8'h00;
      hw_reset_pulse <= 1'b0;
      reset_pending  <= 1'b0;
    end else begin
      hw_reset_pulse <= do_reset;
      reset_pending  <= do_reset;
      if (do_reset | reset_pending) begin
        vector    <= VECTOR_RESET;
        bus.rdata <= 8'h00;
      end else begin
        if (vec_write)
          vector <= bus.wdata;
        if (reg_read)
          bus.rdata <= next_rdata;
        else if (ack_read & chain_claim)
          bus.rdata <= vector;
      end
    end
  end
endmodule // hprac_device

// File: bench/hprac_properties.sv
`timescale 1ns/1ps
module hprac_properties
  import hprac_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // host bus
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       ce_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rdata_oe,
  input wire logic       irq_acknowledge_n,
  input wire logic       priority_chain_in,
  input wire logic       priority_chain_out
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // strobe checks
  // ****************************************************************
  both_low_hold_a :
    assert property ($fell(rd_n | wr_n) && !rd_n && !wr_n |-> (!rd_n && !wr_n) [*8])
    else $error("coincident strobes released early");
  write_width_a :
    assert property ($fell(wr_n) && rd_n |-> (!wr_n && rd_n && $stable(wdata)) [*8])
    else $error("write strobe or data unsteady");
  write_recover_a :
    assert property ($rose(wr_n) |-> (wr_n && rd_n) [*4])
    else $error("access recovery too short");
  // ****************************************************************
  // read data checks
  // ****************************************************************
  status0_pattern_a :
    assert property (!rd_n && wr_n && !ce_n && irq_acknowledge_n && addr == REG_STATUS0 && $past(!rd_n, 2)
      |-> rdata[7:6] == STATUS0_HIGH && rdata[2:0] == STATUS0_LOW)
    else $error("status 0 fixed bits wrong");
  status1_pattern_a :
    assert property (!rd_n && wr_n && !ce_n && irq_acknowledge_n && addr == REG_STATUS1 && $past(!rd_n, 2)
      |-> rdata[7] == 1'b0 && rdata[5:0] == STATUS1_LOW)
    else $error("status 1 fixed bits wrong");
  data_float_a :
    assert property ((rdata_oe |-> !rd_n) and (!rd_n && wr_n && !ce_n && irq_acknowledge_n |-> rdata_oe))
    else $error("read data driven without read strobe");
  // ****************************************************************
  // priority chain checks
  // ****************************************************************
  chain_block_a :
    assert property (priority_chain_out |-> priority_chain_in)
    else $error("chain out high without chain in");
  ack_wait_a :
    assert property ($fell(irq_acknowledge_n) |-> rd_n [*4])
    else $error("acknowledge read strobe too early");
endmodule // hprac_properties

// File: bench/host_port_reset_and_access_control_tb.sv
`timescale 1ns/1ps
module host_port_reset_and_access_control_tb;
  import hprac_pkg::*;
  logic       clk, rst_n, ext_status1, irq_pending, hw_reset_pulse, req_valid, chain_in, req_ready, rsp_valid;
  logic [2:0] ext_inputs;
  logic [7:0] vector, req_wdata, rsp_rdata, q;
  logic [3:0] req_addr;
  hprac_op_t  req_op;
  int         num_errors, n_compared, pulses;
  hprac_if bus ();
  hprac_device i_hprac_device (.clk(clk), .rst_n(rst_n), .bus(bus), .ext_inputs(ext_inputs),
    .ext_status1(ext_status1), .irq_pending(irq_pending), .hw_reset_pulse(hw_reset_pulse), .vector(vector));
  hprac_host i_hprac_host (.clk(clk), .rst_n(rst_n), .bus(bus), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_wdata(req_wdata), .chain_in(chain_in), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  hprac_properties i_hprac_properties (.clk(clk), .rst_n(rst_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
    .ce_n(bus.ce_n), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .rdata_oe(bus.rdata_oe),
    .irq_acknowledge_n(bus.irq_acknowledge_n), .priority_chain_in(bus.priority_chain_in),
    .priority_chain_out(bus.priority_chain_out));
  // ****************************************************************
  // helpers
  // ****************************************************************
  always @(posedge clk) begin
    if (hw_reset_pulse === 1'b1) pulses <= pulses + 1;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic op(input hprac_op_t o, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    q = 8'hXX;
    req_op = o;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
      if (rsp_valid === 1'b1) q = rsp_rdata;
    end
    if (n >= 100) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // ****************************************************************
  // clock and sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, req_valid, irq_pending, num_errors, n_compared, pulses} = '0;
    {ext_inputs, ext_status1, chain_in, req_addr, req_wdata} = {3'h5, 1'b1, 1'b1, 4'h0, 8'h00};
    req_op = HPRAC_OP_READ;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    op(HPRAC_OP_READ, REG_STATUS0, 8'h00);
    op(HPRAC_OP_READ, REG_STATUS1, 8'h00);
    op(HPRAC_OP_WRITE, REG_MASTER, 8'h40);
    check(8'(pulses), 8'h00);
    op(HPRAC_OP_WRITE, REG_MASTER, RESET_COMMAND);
    check(8'(pulses), 8'h01);
    op(HPRAC_OP_READ, REG_STATUS0, 8'h00);
    check(q, {STATUS0_HIGH, ext_inputs, STATUS0_LOW});
    op(HPRAC_OP_READ, REG_STATUS1, 8'h00);
    check(q, {1'b0, ext_status1, STATUS1_LOW});
    op(HPRAC_OP_WRITE, REG_VECTOR, 8'hA5);
    op(HPRAC_OP_READ, REG_VECTOR, 8'h00);
    check(q, 8'hA5);
    check(vector, 8'hA5);
    op(HPRAC_OP_WRITE, REG_MASTER, RESET_COMMAND);
    check(8'(pulses), 8'h02);
    op(HPRAC_OP_READ, REG_VECTOR, 8'h00);
    check(q, VECTOR_RESET);
    {ext_inputs, ext_status1} = {3'h2, 1'b0};
    op(HPRAC_OP_READ, REG_STATUS0, 8'h00);
    check(q, {STATUS0_HIGH, 3'h2, STATUS0_LOW});
    op(HPRAC_OP_READ, REG_STATUS1, 8'h00);
    check(q, {2'b00, STATUS1_LOW});
    op(HPRAC_OP_WRITE, REG_VECTOR, 8'h3C);
    op(HPRAC_OP_RESET, 4'h0, 8'h00);
    check(8'(pulses), 8'h03);
    op(HPRAC_OP_READ, REG_VECTOR, 8'h00);
    check(q, VECTOR_RESET);
    op(HPRAC_OP_WRITE, 4'h5, 8'hFF);
    op(HPRAC_OP_READ, 4'h5, 8'h00);
    check(q, 8'h00);
    op(HPRAC_OP_WRITE, REG_VECTOR, 8'h5A);
    irq_pending = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, bus.priority_chain_out}, 8'h00);
    op(HPRAC_OP_ACK, 4'h0, 8'h00);
    check(vector, 8'h5A);
    check(q, 8'h5A);
    irq_pending = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, bus.priority_chain_out}, 8'h01);
    report_and_stop();
  end
endmodule // host_port_reset_and_access_control_tb
